// ===== common/isc_pkg.sv
// constants and carrier types of the interrupt source control block
`default_nettype none
package isc_pkg;

  // ----------------------------------------------------------------
  // register addresses
  // ----------------------------------------------------------------
  localparam logic [15:0] ADDR_WAKEUP_EDGE_SELECT  = 16'hFF90;
  localparam logic [15:0] ADDR_EVENT_STATUS        = 16'hFF91;
  localparam logic [15:0] ADDR_EVENT_MASK          = 16'hFF92;
  localparam logic [15:0] ADDR_EXT_REQ_EDGE_SELECT = 16'hFFF2;
  localparam logic [15:0] ADDR_INT_ENABLE_ONE      = 16'hFFF3;
  localparam logic [15:0] ADDR_INT_ENABLE_TWO      = 16'hFFF4;
  localparam logic [15:0] ADDR_INT_FLAGS_ONE       = 16'hFFF6;
  localparam logic [15:0] ADDR_INT_FLAGS_TWO       = 16'hFFF7;
  localparam logic [15:0] ADDR_WAKEUP_FLAGS        = 16'hFFF9;

  // ----------------------------------------------------------------
  // reset values and fixed bits
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_EDGE_SELECT  = 8'hE0;
  localparam logic [7:0] EDGE_SELECT_ONES = 8'hE0;
  localparam logic [7:0] RST_FLAGS_ONE    = 8'h20;
  localparam logic [7:0] FLAGS_ONE_ONES   = 8'h20;
  localparam logic [7:0] RST_ZERO         = 8'h00;
  localparam logic [2:0] RST_EVENT        = 3'h0;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int EXT_LINES  = 5;
  localparam int WAKE_LINES = 8;
  localparam int INT_EVENTS = 23;
  // enable one / flags one
  localparam int B1_TIMER_A = 7;
  localparam int B1_WAKE    = 5;
  // enable two / flags two
  localparam int B2_DIRECT  = 7;
  localparam int B2_CONV    = 6;
  localparam int B2_TIMER_G = 4;
  localparam int B2_TFH     = 3;
  localparam int B2_TFL     = 2;
  localparam int B2_TIMER_C = 1;
  localparam int B2_ASYNC   = 0;
  localparam logic [7:0] FLAGS_TWO_USED = 8'hDF;
  localparam logic [7:0] FLAGS_ONE_USED = 8'h9F;
  // event status bits
  localparam int EV_EXT_EDGE = 0;
  localparam int EV_INT_REQ  = 1;
  localparam int EV_BLOCKED  = 2;

  // ----------------------------------------------------------------
  // internal event input positions
  // ----------------------------------------------------------------
  localparam int IN_TA      = 0;
  localparam int IN_AEC     = 1;
  localparam int IN_TC_OVF  = 2;
  localparam int IN_TC_UDF  = 3;
  localparam int IN_TFL_CM  = 4;
  localparam int IN_TFL_OVF = 5;
  localparam int IN_TFH_CM  = 6;
  localparam int IN_TFH_OVF = 7;
  localparam int IN_TG_CAP  = 8;
  localparam int IN_TG_OVF  = 9;
  localparam int IN_SCI1_LO = 10;
  localparam int IN_SCI1_HI = 15;
  localparam int IN_SCI2_LO = 16;
  localparam int IN_SCI2_HI = 21;
  localparam int IN_AD      = 22;

  // ----------------------------------------------------------------
  // vector numbers
  // ----------------------------------------------------------------
  localparam logic [4:0] VEC_EXT0   = 5'h04;
  localparam logic [4:0] VEC_WAKE   = 5'h09;
  localparam logic [4:0] VEC_TA     = 5'h0B;
  localparam logic [4:0] VEC_AEC    = 5'h0C;
  localparam logic [4:0] VEC_TC     = 5'h0D;
  localparam logic [4:0] VEC_TFL    = 5'h0E;
  localparam logic [4:0] VEC_TFH    = 5'h0F;
  localparam logic [4:0] VEC_TG     = 5'h10;
  localparam logic [4:0] VEC_SCI1   = 5'h11;
  localparam logic [4:0] VEC_SCI2   = 5'h12;
  localparam logic [4:0] VEC_AD     = 5'h13;
  localparam logic [4:0] VEC_DIRECT = 5'h14;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
  } isc_bus_req_t;

  typedef struct packed {
    logic        req;
    logic [4:0]  vector;
    logic [15:0] vec_addr;
  } isc_cpu_req_t;

endpackage
`default_nettype wire

// ===== design/isc_top.sv
// interrupt source control: edge detect, flags, enables, priority select
`default_nettype none

// Behaviour
// - take 13 external, 23 internal request sources
// - forward only highest priority pending source
// - mask bit set: flags still set, none accepted
// - each pin selects rising or falling edge
// - lower vector wins; pins 4..8, wake 9
// - timer A vector 11, async counter 12
// - timer C vector 13; timer F 14, 15
// - G 16, serials 17/18, converter 19, direct 20
// - never fetch from reserved vector addresses
// - flag registers clear on written zero only
// - edge-select low five bits pick pin polarity
// - edge-select top three bits read one
// - edge bit 4 also sets trigger polarity
// - registers take documented values at reset
// - zero selects falling, one selects rising
// - enable bit zero blocks, one passes request
module isc_top (
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   rst,
  // register port
  input  wire isc_pkg::isc_bus_req_t  bus_req,
  output logic [7:0]                  bus_rdata,
  // request pins
  input  wire logic [4:0]             ext_line,
  input  wire logic [7:0]             wake_line,
  input  wire logic                   converter_ext_trigger,
  output logic                        converter_trigger_pulse,
  // peripheral requests
  input  wire logic [22:0]            periph_event,
  input  wire logic                   direct_transfer_req,
  // cpu side
  input  wire logic                   cpu_global_mask,
  output isc_pkg::isc_cpu_req_t       cpu_req,
  // event interrupt
  output logic                        event_irq
);

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  logic [4:0]  edge_pol_ff;
  logic [7:0]  wake_pol_ff;
  logic [7:0]  enable_one_ff;
  logic [7:0]  enable_two_ff;
  logic [7:0]  flags_one_ff;
  logic [7:0]  flags_two_ff;
  logic [7:0]  wake_flags_ff;
  logic [2:0]  ev_status_ff;
  logic [2:0]  ev_mask_ff;
  logic [7:0]  rdata_ff;

  logic        wr_edge;
  logic        wr_wpol;
  logic        wr_en1;
  logic        wr_en2;
  logic        wr_f1;
  logic        wr_f2;
  logic        wr_wf;
  logic        wr_evs;
  logic        wr_evm;

  assign wr_edge = bus_req.wr && bus_req.addr == isc_pkg::ADDR_EXT_REQ_EDGE_SELECT;
  assign wr_wpol = bus_req.wr && bus_req.addr == isc_pkg::ADDR_WAKEUP_EDGE_SELECT;
  assign wr_en1  = bus_req.wr && bus_req.addr == isc_pkg::ADDR_INT_ENABLE_ONE;
  assign wr_en2  = bus_req.wr && bus_req.addr == isc_pkg::ADDR_INT_ENABLE_TWO;
  assign wr_f1   = bus_req.wr && bus_req.addr == isc_pkg::ADDR_INT_FLAGS_ONE;
  assign wr_f2   = bus_req.wr && bus_req.addr == isc_pkg::ADDR_INT_FLAGS_TWO;
  assign wr_wf   = bus_req.wr && bus_req.addr == isc_pkg::ADDR_WAKEUP_FLAGS;
  assign wr_evs  = bus_req.wr && bus_req.addr == isc_pkg::ADDR_EVENT_STATUS;
  assign wr_evm  = bus_req.wr && bus_req.addr == isc_pkg::ADDR_EVENT_MASK;

  // ----------------------------------------------------------------
  // pin edge detection
  // ----------------------------------------------------------------
  // primed blocks a false edge from the reset value of the history
  logic        primed_ff;
  logic [4:0]  ext_prev_ff;
  logic [7:0]  wake_prev_ff;
  logic        trig_prev_ff;
  logic [4:0]  ext_edge;
  logic [7:0]  wake_edge;
  logic        trig_edge;

  always_ff @(posedge clk) begin
    if (rst) begin
      primed_ff <= 1'h0;
    end else begin
      primed_ff <= 1'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ext_prev_ff <= 5'h00;
    end else begin
      ext_prev_ff <= ext_line;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wake_prev_ff <= 8'h00;
    end else begin
      wake_prev_ff <= wake_line;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      trig_prev_ff <= 1'h0;
    end else begin
      trig_prev_ff <= converter_ext_trigger;
    end
  end

  always_comb begin
    for (int i = 0; i < isc_pkg::EXT_LINES; i++) begin
      ext_edge[i] = primed_ff && (edge_pol_ff[i] ? (ext_line[i] && !ext_prev_ff[i])
                                                  : (!ext_line[i] && ext_prev_ff[i]));
    end
  end

  always_comb begin
    for (int i = 0; i < isc_pkg::WAKE_LINES; i++) begin
      wake_edge[i] = primed_ff && (wake_pol_ff[i] ? (wake_line[i] && !wake_prev_ff[i])
                                                   : (!wake_line[i] && wake_prev_ff[i]));
    end
  end

  // trigger shares polarity with the fifth request pin
  assign trig_edge = primed_ff && (edge_pol_ff[4] ? (converter_ext_trigger && !trig_prev_ff)
                                                  : (!converter_ext_trigger && trig_prev_ff));

  always_ff @(posedge clk) begin
    if (rst) begin
      converter_trigger_pulse <= 1'h0;
    end else begin
      converter_trigger_pulse <= trig_edge;
    end
  end

  // ----------------------------------------------------------------
  // edge select and enable registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      edge_pol_ff <= isc_pkg::RST_EDGE_SELECT[4:0];
    end else begin
      if (wr_edge) begin
        edge_pol_ff <= bus_req.wdata[4:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wake_pol_ff <= isc_pkg::RST_ZERO;
    end else begin
      if (wr_wpol) begin
        wake_pol_ff <= bus_req.wdata;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      enable_one_ff <= isc_pkg::RST_ZERO;
    end else begin
      if (wr_en1) begin
        enable_one_ff <= bus_req.wdata;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      enable_two_ff <= isc_pkg::RST_ZERO;
    end else begin
      if (wr_en2) begin
        enable_two_ff <= bus_req.wdata;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ev_mask_ff <= isc_pkg::RST_EVENT;
    end else begin
      if (wr_evm) begin
        ev_mask_ff <= bus_req.wdata[2:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // request flags
  // ----------------------------------------------------------------
  // a flag is set whatever the enable or cpu mask; set beats clear
  logic [7:0] set_one;
  logic [7:0] set_two;
  logic [7:0] clr_one;
  logic [7:0] clr_two;
  logic [7:0] clr_wake;

  always_comb begin
    set_one = 8'h00;
    set_one[4:0] = ext_edge;
    set_one[isc_pkg::B1_TIMER_A] = periph_event[isc_pkg::IN_TA];
  end

  always_comb begin
    set_two = 8'h00;
    set_two[isc_pkg::B2_ASYNC]   = periph_event[isc_pkg::IN_AEC];
    set_two[isc_pkg::B2_TIMER_C] = periph_event[isc_pkg::IN_TC_OVF] || periph_event[isc_pkg::IN_TC_UDF];
    set_two[isc_pkg::B2_TFL]     = periph_event[isc_pkg::IN_TFL_CM] || periph_event[isc_pkg::IN_TFL_OVF];
    set_two[isc_pkg::B2_TFH]     = periph_event[isc_pkg::IN_TFH_CM] || periph_event[isc_pkg::IN_TFH_OVF];
    set_two[isc_pkg::B2_TIMER_G] = periph_event[isc_pkg::IN_TG_CAP] || periph_event[isc_pkg::IN_TG_OVF];
    set_two[isc_pkg::B2_CONV]    = periph_event[isc_pkg::IN_AD];
    set_two[isc_pkg::B2_DIRECT]  = direct_transfer_req;
  end

  always_comb begin
    clr_one  = wr_f1 ? ~bus_req.wdata & isc_pkg::FLAGS_ONE_USED : 8'h00;
    clr_two  = wr_f2 ? ~bus_req.wdata & isc_pkg::FLAGS_TWO_USED : 8'h00;
    clr_wake = wr_wf ? ~bus_req.wdata : 8'h00;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      flags_one_ff <= isc_pkg::RST_FLAGS_ONE & isc_pkg::FLAGS_ONE_USED;
    end else begin
      flags_one_ff <= (flags_one_ff & ~clr_one) | set_one;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      flags_two_ff <= isc_pkg::RST_ZERO;
    end else begin
      flags_two_ff <= (flags_two_ff & ~clr_two) | set_two;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wake_flags_ff <= isc_pkg::RST_ZERO;
    end else begin
      wake_flags_ff <= (wake_flags_ff & ~clr_wake) | wake_edge;
    end
  end

  // ----------------------------------------------------------------
  // candidates and priority select
  // ----------------------------------------------------------------
  logic [31:0] cand;
  logic        any_cand;
  logic [4:0]  win_vec;
  logic        sci1_req;
  logic        sci2_req;
  logic        pending;

  // serial channels keep their own flags and enables inside the channel
  assign sci1_req = |periph_event[isc_pkg::IN_SCI1_HI:isc_pkg::IN_SCI1_LO];
  assign sci2_req = |periph_event[isc_pkg::IN_SCI2_HI:isc_pkg::IN_SCI2_LO];

  always_comb begin
    cand = 32'h0000_0000;
    for (int i = 0; i < isc_pkg::EXT_LINES; i++) begin
      cand[isc_pkg::VEC_EXT0 + 5'(i)] = flags_one_ff[i] && enable_one_ff[i];
    end
    cand[isc_pkg::VEC_WAKE] = |wake_flags_ff && enable_one_ff[isc_pkg::B1_WAKE];
    cand[isc_pkg::VEC_TA]   = flags_one_ff[isc_pkg::B1_TIMER_A] && enable_one_ff[isc_pkg::B1_TIMER_A];
    cand[isc_pkg::VEC_AEC]  = flags_two_ff[isc_pkg::B2_ASYNC] && enable_two_ff[isc_pkg::B2_ASYNC];
    cand[isc_pkg::VEC_TC]   = flags_two_ff[isc_pkg::B2_TIMER_C] && enable_two_ff[isc_pkg::B2_TIMER_C];
    cand[isc_pkg::VEC_TFL]  = flags_two_ff[isc_pkg::B2_TFL] && enable_two_ff[isc_pkg::B2_TFL];
    cand[isc_pkg::VEC_TFH]  = flags_two_ff[isc_pkg::B2_TFH] && enable_two_ff[isc_pkg::B2_TFH];
    cand[isc_pkg::VEC_TG]   = flags_two_ff[isc_pkg::B2_TIMER_G] && enable_two_ff[isc_pkg::B2_TIMER_G];
    cand[isc_pkg::VEC_SCI1] = sci1_req;
    cand[isc_pkg::VEC_SCI2] = sci2_req;
    cand[isc_pkg::VEC_AD]   = flags_two_ff[isc_pkg::B2_CONV] && enable_two_ff[isc_pkg::B2_CONV];
    cand[isc_pkg::VEC_DIRECT] = flags_two_ff[isc_pkg::B2_DIRECT] && enable_two_ff[isc_pkg::B2_DIRECT];
  end

  // scan downward so the lowest pending vector is the last one kept
  always_comb begin
    win_vec = isc_pkg::VEC_DIRECT;
    for (int v = 31; v >= 0; v--) begin
      if (cand[v]) begin
        win_vec = 5'(v);
      end
    end
  end

  // only vectors 4..9 and 11..20 exist, so reserved addresses never appear
  assign pending  = |cand;
  assign any_cand = pending && !cpu_global_mask;

  always_ff @(posedge clk) begin
    if (rst) begin
      cpu_req.req      <= 1'h0;
      cpu_req.vector   <= 5'h00;
      cpu_req.vec_addr <= 16'h0000;
    end else begin
      cpu_req.req      <= any_cand;
      cpu_req.vector   <= any_cand ? win_vec : 5'h00;
      cpu_req.vec_addr <= any_cand ? {10'h000, win_vec, 1'h0} : 16'h0000;
    end
  end

  // ----------------------------------------------------------------
  // event status, mask and interrupt line
  // ----------------------------------------------------------------
  logic [2:0] ev_set;

  always_comb begin
    ev_set = 3'h0;
    ev_set[isc_pkg::EV_EXT_EDGE] = |ext_edge || |wake_edge;
    ev_set[isc_pkg::EV_INT_REQ]  = |set_two || set_one[isc_pkg::B1_TIMER_A];
    ev_set[isc_pkg::EV_BLOCKED]  = pending && cpu_global_mask;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ev_status_ff <= isc_pkg::RST_EVENT;
    end else begin
      ev_status_ff <= (ev_status_ff & ~(wr_evs ? bus_req.wdata[2:0] : 3'h0)) | ev_set;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      event_irq <= 1'h0;
    end else begin
      event_irq <= |(((ev_status_ff & ~(wr_evs ? bus_req.wdata[2:0] : 3'h0)) | ev_set) & ev_mask_ff);
    end
  end

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  logic [7:0] rd_mux;

  always_comb begin
    case (bus_req.addr)
      isc_pkg::ADDR_EXT_REQ_EDGE_SELECT: rd_mux = isc_pkg::EDGE_SELECT_ONES | {3'h0, edge_pol_ff};
      isc_pkg::ADDR_WAKEUP_EDGE_SELECT:  rd_mux = wake_pol_ff;
      isc_pkg::ADDR_INT_ENABLE_ONE:      rd_mux = enable_one_ff;
      isc_pkg::ADDR_INT_ENABLE_TWO:      rd_mux = enable_two_ff;
      isc_pkg::ADDR_INT_FLAGS_ONE:       rd_mux = flags_one_ff | isc_pkg::FLAGS_ONE_ONES;
      isc_pkg::ADDR_INT_FLAGS_TWO:       rd_mux = flags_two_ff;
      isc_pkg::ADDR_WAKEUP_FLAGS:        rd_mux = wake_flags_ff;
      isc_pkg::ADDR_EVENT_STATUS:        rd_mux = {5'h00, ev_status_ff};
      isc_pkg::ADDR_EVENT_MASK:          rd_mux = {5'h00, ev_mask_ff};
      default:                           rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_ff <= 8'h00;
    end else begin
      rdata_ff <= bus_req.rd ? rd_mux : 8'h00;
    end
  end

  assign bus_rdata = rdata_ff;

endmodule
`default_nettype wire

// ===== test/isc_periph_model.sv
// request source model: timer, converter, serial and direct transfer events
`default_nettype none
module isc_periph_model (
  // clock
  input  wire logic        clk,
  // commands from the bench
  input  wire logic [23:0] fire,
  input  wire logic [1:0]  ser,
  // request lines toward the block
  output logic      [22:0] periph_event,
  output logic             direct_transfer_req
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // event lines
  // ----------------------------------------------------------------
  logic [23:0] pulse_ff;
  // one clock per command, so a pulse never stretches
  always_ff @(posedge clk) begin
    pulse_ff <= fire;
  end
  // serial requests are levels held by the channel until served
  assign periph_event        = {pulse_ff[22], {6{ser[1]}}, {6{ser[0]}}, pulse_ff[9:0]};
  assign direct_transfer_req = pulse_ff[23];
endmodule
`default_nettype wire

// ===== test/isc_chk.sv
// assertion checker for the interrupt source control block
`default_nettype none
module isc_chk (
  // clock and reset
  input wire logic                  clk,
  input wire logic                  rst,
  // register port
  input wire isc_pkg::isc_bus_req_t bus_req,
  input wire logic [7:0]            bus_rdata,
  // trigger pin
  input wire logic                  converter_ext_trigger,
  input wire logic                  converter_trigger_pulse,
  // cpu side
  input wire logic                  cpu_global_mask,
  input wire isc_pkg::isc_cpu_req_t cpu_req,
  input wire logic                  event_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  mask_block_a: assert property (cpu_global_mask |=> !cpu_req.req)
    else $error("cpu request raised while masked");
  unmask_rise_a: assert property ($rose(cpu_req.req) |-> !$past(cpu_global_mask))
    else $error("cpu request rose after a masked cycle");
  vec_addr_a: assert property (cpu_req.req |-> cpu_req.vec_addr == {10'h000, cpu_req.vector, 1'h0})
    else $error("vector address is not twice the vector");
  vec_legal_a: assert property (cpu_req.req |-> cpu_req.vector inside {[5'h04:5'h09], [5'h0B:5'h14]})
    else $error("vector outside the used set");
  idle_zero_a: assert property (!cpu_req.req |-> cpu_req.vector == 5'h00 && cpu_req.vec_addr == 16'h0000)
    else $error("vector shown without request");
  rdata_idle_a: assert property (!bus_req.rd |=> bus_rdata == 8'h00)
    else $error("read data outside read answer cycle");
  edge_ones_a: assert property (bus_req.rd && bus_req.addr == isc_pkg::ADDR_EXT_REQ_EDGE_SELECT
    |=> bus_rdata[7:5] == 3'h7)
    else $error("edge select top bits not read as ones");
  trig_cause_a: assert property (converter_trigger_pulse
    |-> $past(converter_ext_trigger, 2) != $past(converter_ext_trigger) ##1 !converter_trigger_pulse)
    else $error("trigger pulse without a pin edge or too long");

  cover property ($rose(cpu_req.req));
  cover property (converter_trigger_pulse);
  cover property ($rose(event_irq));
endmodule

bind isc_top isc_chk u_chk (
  .clk(clk), .rst(rst), .bus_req(bus_req), .bus_rdata(bus_rdata),
  .converter_ext_trigger(converter_ext_trigger), .converter_trigger_pulse(converter_trigger_pulse),
  .cpu_global_mask(cpu_global_mask), .cpu_req(cpu_req), .event_irq(event_irq)
);
`default_nettype wire

// ===== test/testbench.sv
// self-checking bench of the interrupt source control block
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic                  clk;
  logic                  rst;
  isc_pkg::isc_bus_req_t bus_req;
  logic [7:0]            bus_rdata;
  logic [4:0]            ext_line;
  logic [7:0]            wake_line;
  logic                  trig;
  logic                  trig_pulse;
  logic [22:0]           periph_event;
  logic                  direct_req;
  logic                  cpu_mask;
  isc_pkg::isc_cpu_req_t cpu_req;
  logic                  event_irq;
  logic [23:0]           fire;
  logic [1:0]            ser;
  int                    mismatches;
  int                    comparisons;
  // event index, flag register low byte, flag bit, vector
  logic [31:0] tbl [12] = '{32'h00F6070B, 32'h01F7000C, 32'h02F7010D, 32'h03F7010D, 32'h04F7020E,
    32'h05F7020E, 32'h06F7030F, 32'h07F7030F, 32'h08F70410, 32'h09F70410, 32'h16F70613, 32'h17F70714};

  isc_periph_model u_model (.clk(clk), .fire(fire), .ser(ser), .periph_event(periph_event),
    .direct_transfer_req(direct_req));
  isc_top u_dut (.clk(clk), .rst(rst), .bus_req(bus_req), .bus_rdata(bus_rdata), .ext_line(ext_line),
    .wake_line(wake_line), .converter_ext_trigger(trig), .converter_trigger_pulse(trig_pulse),
    .periph_event(periph_event), .direct_transfer_req(direct_req), .cpu_global_mask(cpu_mask),
    .cpu_req(cpu_req), .event_irq(event_irq));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus_req <= '0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rchk(input logic [15:0] a, input logic [7:0] e);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus_req <= '0;
    #1;
    chk($sformatf("register %h", a), e, bus_rdata);
  endtask
  task automatic cpu_chk(input logic [4:0] v);
    isc_pkg::isc_cpu_req_t e;
    e = '0;
    if (v != 5'h00) begin
      e = '{req: 1'b1, vector: v, vec_addr: {10'h000, v, 1'b0}};
    end
    repeat (3) @(posedge clk);
    #1;
    comparisons++;
    if (cpu_req !== e) begin
      mismatches++;
      $display("[FAIL] cpu_req expected %h seen %h", e, cpu_req);
    end
  endtask
  task automatic pins(input logic [4:0] e, input logic [7:0] w);
    @(posedge clk);
    ext_line <= e;
    wake_line <= w;
    repeat (3) @(posedge clk);
  endtask
  task automatic trig_set(input logic v, input logic [7:0] n);
    logic [7:0] c;
    c = 8'h00;
    @(posedge clk);
    trig <= v;
    repeat (5) begin
      @(posedge clk);
      #1;
      if (trig_pulse === 1'b1) c++;
    end
    chk("trigger pulses", n, c);
  endtask
  task automatic irq_chk(input logic v);
    repeat (2) @(posedge clk);
    #1;
    chk("event irq", {7'h00, v}, {7'h00, event_irq});
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    logic [15:0] a [8] = '{16'hFF90, 16'hFFF2, 16'hFFF3, 16'hFFF4, 16'hFFF6, 16'hFFF7, 16'hFFF9, 16'hFF00};
    logic [7:0]  e [8] = '{8'h00, 8'hE0, 8'h00, 8'h00, 8'h20, 8'h00, 8'h00, 8'h00};
    for (int i = 0; i < 8; i++) begin
      rchk(a[i], e[i]);
    end
  endtask
  task automatic t_trig();
    trig_set(1'b0, 8'h01);
    trig_set(1'b1, 8'h00);
    wr(16'hFFF2, 8'h10);
    rchk(16'hFFF2, 8'hF0);
    trig_set(1'b0, 8'h00);
    trig_set(1'b1, 8'h01);
    wr(16'hFFF2, 8'h00);
  endtask
  task automatic t_int();
    logic [7:0] e;
    wr(16'hFFF3, 8'h80);
    wr(16'hFFF4, 8'hFF);
    for (int i = 0; i < 12; i++) begin
      e = 8'h01 << tbl[i][15:8];
      @(posedge clk);
      fire <= 24'h000001 << tbl[i][31:24];
      @(posedge clk);
      fire <= 24'h000000;
      cpu_chk(tbl[i][4:0]);
      rchk({8'hFF, tbl[i][23:16]}, e | ((tbl[i][23:16] == 8'hF6) ? 8'h20 : 8'h00));
      wr({8'hFF, tbl[i][23:16]}, ~e);
      cpu_chk(5'h00);
    end
  endtask
  // all peripheral pulse sources at once while masked, then served lowest vector first; serial levels after
  task automatic t_prio();
    @(posedge clk);
    cpu_mask <= 1'b1;
    fire <= 24'hC003FF;
    @(posedge clk);
    fire <= 24'h000000;
    cpu_chk(5'h00);
    rchk(16'hFFF7, 8'hDF);
    @(posedge clk);
    cpu_mask <= 1'b0;
    for (int i = 0; i < 12; i++) begin
      if (i == 0 || tbl[i][4:0] != tbl[i-1][4:0]) begin
        cpu_chk(tbl[i][4:0]);
        wr({8'hFF, tbl[i][23:16]}, ~(8'h01 << tbl[i][15:8]));
      end
    end
    @(posedge clk);
    ser <= 2'b11;
    cpu_chk(5'h11);
    @(posedge clk);
    ser <= 2'b10;
    cpu_chk(5'h12);
    @(posedge clk);
    ser <= 2'b00;
    cpu_chk(5'h00);
  endtask
  task automatic t_irq();
    wr(16'hFF91, 8'h07);
    wr(16'hFF92, 8'h01);
    pins(5'h1E, 8'hF0);
    irq_chk(1'b1);
    wr(16'hFF92, 8'h00);
    irq_chk(1'b0);
    wr(16'hFF92, 8'h01);
    irq_chk(1'b1);
    wr(16'hFF91, 8'h01);
    irq_chk(1'b0);
    pins(5'h1F, 8'hF0);
    wr(16'hFFF6, 8'h00);
    wr(16'hFF91, 8'h07);
  endtask
  task automatic t_wake();
    wr(16'hFF90, 8'h0F);
    pins(5'h1F, 8'h0F);
    rchk(16'hFFF9, 8'hFF);
    wr(16'hFFF3, 8'h20);
    cpu_chk(5'h09);
    wr(16'hFFF9, 8'hFE);
    rchk(16'hFFF9, 8'hFE);
    wr(16'hFFF9, 8'h00);
    cpu_chk(5'h00);
    pins(5'h1F, 8'hF0);
    rchk(16'hFFF9, 8'h00);
  endtask
  task automatic t_pins();
    logic [4:0] idle;
    logic [4:0] b;
    for (int p = 0; p < 2; p++) begin
      idle = (p == 1) ? 5'h00 : 5'h1F;
      wr(16'hFFF2, (p == 1) ? 8'h1F : 8'h00);
      pins(idle, 8'hF0);
      rchk(16'hFFF6, 8'h20);
      for (int i = 0; i < 5; i++) begin
        b = 5'h01 << i;
        wr(16'hFFF3, 8'h00);
        pins(idle ^ b, 8'hF0);
        rchk(16'hFFF6, {3'b001, b});
        cpu_chk(5'h00);
        wr(16'hFFF3, {3'b000, b});
        cpu_chk(5'h04 + i[4:0]);
        wr(16'hFFF6, 8'hFF);
        cpu_chk(5'h04 + i[4:0]);
        wr(16'hFFF6, ~{3'b000, b});
        cpu_chk(5'h00);
        pins(idle, 8'hF0);
        rchk(16'hFFF6, 8'h20);
      end
    end
  endtask
  // ----------------------------------------------------------------
  // sequence and verdict
  // ----------------------------------------------------------------
  task automatic end_sim();
    if (mismatches == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    rst = 1'b1;
    bus_req = '0;
    ext_line = 5'h1F;
    wake_line = 8'hF0;
    trig = 1'b1;
    fire = 24'h000000;
    ser = 2'b00;
    cpu_mask = 1'b0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    t_regs();
    t_trig();
    t_int();
    t_prio();
    t_irq();
    t_wake();
    t_pins();
    end_sim();
  end
  // the whole sequence needs well under two thousand cycles
  initial begin
    #100000;
    mismatches++;
    end_sim();
  end
endmodule
`default_nettype wire
